// ---- hw/difm_consts.svh ----
// Address map, function codes, limits and reset values of the input function mapper
`ifndef DIFM_CONSTS_SVH
`define DIFM_CONSTS_SVH

// Sizes
`define DIFM_NUM_TERM      9
`define DIFM_NUM_FUNC      36
`define DIFM_NUM_PRESET    15
`define DIFM_NUM_RAMP      8

// Word addresses on the register port
`define DIFM_ADDR_TERM     6'h00
`define DIFM_ADDR_PRESET   6'h10
`define DIFM_ADDR_RAMP     6'h20
`define DIFM_ADDR_STATUS   6'h30
`define DIFM_ADDR_ACT_LO   6'h31
`define DIFM_ADDR_ACT_HI   6'h32

// Status register fields
`define DIFM_STAT_RAMP_LSB 4
`define DIFM_STAT_ERR_BIT  6
`define DIFM_STAT_TERM_LSB 16

// Function codes
`define DIFM_CODE_SPEED0   6'h00
`define DIFM_CODE_RAMP0    6'h04
`define DIFM_CODE_RAMP1    6'h05
`define DIFM_CODE_EXT_ALM  6'h09
`define DIFM_CODE_FSRC     6'h0B
`define DIFM_CODE_ALT_FSRC 6'h23

// Limits in 0.01 Hz and 0.01 s units
`define DIFM_PRESET_MAX    32'h0000_2EE0
`define DIFM_RAMP_MIN      32'h0000_0001
`define DIFM_RAMP_MAX      32'h0005_7E40
`define DIFM_RAMP_RST      19'h0_0258

`endif

// ---- hw/difm_pkg.sv ----
// Types shared by the input function mapper files
package difm_pkg;
  typedef logic [5:0]  difm_code_t;   // Terminal function code
  typedef logic [13:0] difm_freq_t;   // Frequency, 0.01 Hz per step
  typedef logic [18:0] difm_time_t;   // Ramp time, 0.01 s per step
endpackage

// ---- hw/difm_sync.sv ----
// Two-stage synchroniser for the terminal inputs
`timescale 1ns/1ps
module difm_sync #(
  parameter int WIDTH = 9
) (
  input  wire logic             sys_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      meta   <= '0;
      sync_o <= '0;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule // difm_sync

// ---- hw/difm_mapper.sv ----
// Digital input terminal function mapper with preset speed and ramp selection
// How it works
// - Nine input terminals each carry their own function code register, set independently.
// - Codes 0-3 are speed select bits 1,2,4,8, 4-5 ramp bits, 6 hold, 7 coast, 8 reset, 9 alarm, 10 inch.
// - Codes 11-18 are source switch, motor set, DC brake, torque limit, line 50/60, up and down.
// - Codes 19-22, 24-26, 30, 31 and 35 are edit, PID bypass, inverse, interlock, link, etc.
// - A function no terminal is assigned to reads as deasserted.
// - Speed select bits form a 4-bit index; zero picks the normal source, n picks preset n.
// - Ramp bits form a 2-bit index picking time pair 1 to 4, each from 0.01 s to 3600 s.
// - Assigning both source switch codes 11 and 35 is rejected and flags a setting error.
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "difm_consts.svh"
module difm_mapper (
  input  wire logic                     sys_clk_i,
  input  wire logic                     sys_rst_i,
  input  wire logic [8:0]               term_i,
  input  wire logic [5:0]               bus_addr_i,
  input  wire logic [31:0]              bus_wdata_i,
  input  wire logic                     bus_wr_i,
  input  wire logic                     bus_rd_i,
  output logic      [31:0]              bus_rdata_o,
  input  wire difm_pkg::difm_freq_t     freq_cmd_i,
  output difm_pkg::difm_freq_t          freq_sel_o,
  output logic                          preset_sel_o,
  output logic      [3:0]               speed_idx_o,
  output logic      [1:0]               ramp_idx_o,
  output difm_pkg::difm_time_t          acc_time_o,
  output difm_pkg::difm_time_t          dec_time_o,
  output logic      [35:0]              func_act_o,
  output logic                          ext_alarm_o,
  output logic                          setting_error_o
);
  logic [8:0]             term_s;
  difm_pkg::difm_code_t   code_q [0:8];
  difm_pkg::difm_freq_t   preset_mem [1:15];
  difm_pkg::difm_time_t   ramp_mem [0:7];
  logic [35:0]            code_ok;
  logic [35:0]            next_func;
  logic [35:0][8:0]       hit;
  logic [8:0]             fsrc_at;
  logic [8:0]             alt_at;
  logic                   term_wr;
  logic [3:0]             term_idx;
  logic                   conflict;
  logic                   preset_wr;
  logic                   ramp_wr;
  logic                   ext_assigned;

  // Closed contact drives the terminal high
  difm_sync #(.WIDTH(`DIFM_NUM_TERM)) u_sync (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (term_i),
    .sync_o    (term_s)
  );

  // Codes that carry a function; gaps and codes above 35 do nothing
  function automatic logic code_valid(input int c);
    return (c <= 22) || (c >= 24 && c <= 26) || c == 30 || c == 31 || c == 35;
  endfunction

  // One match per function and terminal; shared codes are ORed
  genvar gf, gt;
  generate
    for (gf = 0; gf < `DIFM_NUM_FUNC; gf++) begin : g_func
      assign code_ok[gf] = code_valid(gf);
      for (gt = 0; gt < `DIFM_NUM_TERM; gt++) begin : g_term
        assign hit[gf][gt] = code_ok[gf] && (code_q[gt] == 6'(gf));
      end
      assign next_func[gf] = |(hit[gf] & term_s);
    end
    for (gt = 0; gt < `DIFM_NUM_TERM; gt++) begin : g_src
      assign fsrc_at[gt] = (code_q[gt] == `DIFM_CODE_FSRC);
      assign alt_at[gt]  = (code_q[gt] == `DIFM_CODE_ALT_FSRC);
    end
  endgenerate

  assign ext_assigned = |hit[9];

  // Write decode; other terminals only, so rewriting the same slot is fine
  assign term_idx  = bus_addr_i[3:0];
  assign term_wr   = bus_wr_i && (bus_addr_i[5:4] == 2'h0) && (term_idx < 4'h9);
  assign conflict  = term_wr && (
      ((bus_wdata_i[5:0] == `DIFM_CODE_FSRC) && |(alt_at & ~(9'h001 << term_idx))) ||
      ((bus_wdata_i[5:0] == `DIFM_CODE_ALT_FSRC) && |(fsrc_at & ~(9'h001 << term_idx))));
  assign preset_wr = bus_wr_i && (bus_addr_i[5:4] == 2'h1) && (bus_addr_i[3:0] != 4'h0)
                     && (bus_wdata_i <= `DIFM_PRESET_MAX);
  assign ramp_wr   = bus_wr_i && (bus_addr_i[5:3] == 3'h4)
                     && (bus_wdata_i >= `DIFM_RAMP_MIN) && (bus_wdata_i <= `DIFM_RAMP_MAX);

  // Terminal code registers; a conflicting write keeps the old code
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < `DIFM_NUM_TERM; i++) begin
        code_q[i] <= 6'(i);
      end
    end else if (term_wr && !conflict) begin
      code_q[term_idx] <= bus_wdata_i[5:0];
    end
  end

  // Sticky setting error; a fresh conflict beats a software clear
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      setting_error_o <= 1'b0;
    end else if (conflict) begin
      setting_error_o <= 1'b1;
    end else if (bus_wr_i && bus_addr_i == `DIFM_ADDR_STATUS
                 && bus_wdata_i[`DIFM_STAT_ERR_BIT]) begin
      setting_error_o <= 1'b0;
    end
  end

  // Preset table, out-of-range writes are dropped to keep 0..120 Hz
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      for (int i = 1; i <= `DIFM_NUM_PRESET; i++) begin
        preset_mem[i] <= '0;
      end
    end else if (preset_wr) begin
      preset_mem[bus_addr_i[3:0]] <= bus_wdata_i[13:0];
    end
  end

  // Ramp pairs: even word acceleration, odd word deceleration
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < `DIFM_NUM_RAMP; i++) begin
        ramp_mem[i] <= `DIFM_RAMP_RST;
      end
    end else if (ramp_wr) begin
      ramp_mem[bus_addr_i[2:0]] <= bus_wdata_i[18:0];
    end
  end

  // All selections move together on one edge
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      func_act_o   <= '0;
      speed_idx_o  <= 4'h0;
      ramp_idx_o   <= 2'h0;
      preset_sel_o <= 1'b0;
      freq_sel_o   <= '0;
      acc_time_o   <= `DIFM_RAMP_RST;
      dec_time_o   <= `DIFM_RAMP_RST;
      ext_alarm_o  <= 1'b0;
    end else begin
      func_act_o   <= next_func;
      speed_idx_o  <= next_func[3:0];
      ramp_idx_o   <= next_func[5:4];
      preset_sel_o <= |next_func[3:0];
      freq_sel_o   <= (next_func[3:0] == 4'h0) ? freq_cmd_i
                                               : preset_mem[next_func[3:0]];
      acc_time_o   <= ramp_mem[{next_func[5:4], 1'b0}];
      dec_time_o   <= ramp_mem[{next_func[5:4], 1'b1}];
      // Alarm acts on an open contact, and only when a terminal carries it
      ext_alarm_o  <= ext_assigned && !next_func[9];
    end
  end

  // Read data one cycle after the strobe; unmapped words read zero
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      bus_rdata_o <= '0;
    end else if (bus_rd_i) begin
      bus_rdata_o <= '0;
      if (bus_addr_i[5:4] == 2'h0 && term_idx < 4'h9) begin
        bus_rdata_o[5:0] <= code_q[term_idx];
      end else if (bus_addr_i[5:4] == 2'h1 && bus_addr_i[3:0] != 4'h0) begin
        bus_rdata_o[13:0] <= preset_mem[bus_addr_i[3:0]];
      end else if (bus_addr_i[5:3] == 3'h4) begin
        bus_rdata_o[18:0] <= ramp_mem[bus_addr_i[2:0]];
      end else if (bus_addr_i == `DIFM_ADDR_STATUS) begin
        bus_rdata_o[3:0] <= speed_idx_o;
        bus_rdata_o[`DIFM_STAT_RAMP_LSB +: 2] <= ramp_idx_o;
        bus_rdata_o[`DIFM_STAT_ERR_BIT] <= setting_error_o;
        bus_rdata_o[`DIFM_STAT_TERM_LSB +: 9] <= term_s;
      end else if (bus_addr_i == `DIFM_ADDR_ACT_LO) begin
        bus_rdata_o <= func_act_o[31:0];
      end else if (bus_addr_i == `DIFM_ADDR_ACT_HI) begin
        bus_rdata_o[3:0] <= func_act_o[35:32];
      end
    end
  end

  // Checks on the mapper code registers and outputs
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_err_on_conflict: assert property (conflict |=> setting_error_o)
    else $error("setting error not raised on source switch conflict");

  a_conflict_kept: assert property (
    conflict |=> code_q[$past(term_idx)] != `DIFM_CODE_FSRC
                 || code_q[$past(term_idx)] == $past(code_q[term_idx]))
    else $error("conflicting code was stored");

  a_no_dual_src: assert property (!((|fsrc_at) && (|alt_at)))
    else $error("both source switch codes assigned");

  a_invalid_low: assert property ((func_act_o & ~code_ok) == 36'h0_0000_0000)
    else $error("unassigned function asserted");

  a_closed_asserts: assert property (
    (code_q[0] == `DIFM_CODE_SPEED0 && term_i[0])[*3] |=> func_act_o[0])
    else $error("closed terminal not asserted after sync");

  a_same_edge: assert property (
    speed_idx_o == func_act_o[3:0] && ramp_idx_o == func_act_o[5:4]
    && preset_sel_o == (speed_idx_o != 4'h0))
    else $error("selections out of step");

  a_base_source: assert property (
    !$past(sys_rst_i) && speed_idx_o == 4'h0 |-> freq_sel_o == $past(freq_cmd_i))
    else $error("index zero did not pass command frequency");

  a_preset_pick: assert property (
    speed_idx_o != 4'h0 && !$past(preset_wr) |-> freq_sel_o == preset_mem[speed_idx_o])
    else $error("preset not selected");

  a_preset_range: assert property (freq_sel_o <= 14'(`DIFM_PRESET_MAX) || !preset_sel_o)
    else $error("preset above 120 Hz");

  a_ramp_pair: assert property (
    !$past(ramp_wr) |-> acc_time_o == ramp_mem[{ramp_idx_o, 1'b0}]
                        && dec_time_o == ramp_mem[{ramp_idx_o, 1'b1}])
    else $error("ramp pair does not follow index");

  a_ramp_range: assert property (
    acc_time_o >= 19'(`DIFM_RAMP_MIN) && acc_time_o <= 19'(`DIFM_RAMP_MAX)
    && dec_time_o >= 19'(`DIFM_RAMP_MIN) && dec_time_o <= 19'(`DIFM_RAMP_MAX))
    else $error("ramp time out of range");

  c_top_preset: cover property (speed_idx_o == 4'hF);
  c_ramp_four:  cover property (ramp_idx_o == 2'h3);
  c_conflict:   cover property (conflict ##1 setting_error_o);
  c_ext_alarm:  cover property (ext_alarm_o);
endmodule // difm_mapper

// ---- verif/difm_contact_model.sv ----
// Contact model of the switches wired to the nine input terminals
`timescale 1ns/1ps
module difm_contact_model (
  input  wire logic [8:0] press_i,
  output logic      [8:0] term_o
);
  // Contacts settle a few ns after the command, never on a clock edge
  initial term_o = 9'h000;
  always @(press_i) term_o <= #7 press_i;
endmodule // difm_contact_model

// ---- verif/tb_top.sv ----
// Self-checking bench for the input function mapper
`timescale 1ns/1ps
`include "difm_consts.svh"
module tb_top;
  logic                 sys_clk_i = 1'b0;
  logic                 sys_rst_i = 1'b1;
  logic [8:0]           press     = 9'h000;
  logic [8:0]           term;
  logic [5:0]           bus_addr  = 6'h00;
  logic [31:0]          bus_wdata = 32'h0000_0000;
  logic                 bus_wr    = 1'b0;
  logic                 bus_rd    = 1'b0;
  logic [31:0]          rdata;
  logic [31:0]          rd_val;
  difm_pkg::difm_freq_t freq_cmd  = 14'h0123;
  difm_pkg::difm_freq_t freq_sel;
  difm_pkg::difm_time_t acc_time;
  difm_pkg::difm_time_t dec_time;
  logic                 preset_sel;
  logic [3:0]           speed_idx;
  logic [1:0]           ramp_idx;
  logic [35:0]          func_act;
  logic                 ext_alarm;
  logic                 set_err;
  int                   fails       = 0;
  int                   check_count = 0;
  int                   cycles      = 0;

  // 40 MHz system clock
  always #12.5 sys_clk_i = ~sys_clk_i;

  difm_contact_model difm_contact_model_i (.press_i(press), .term_o(term));

  difm_mapper difm_mapper_i (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .term_i(term),
    .bus_addr_i(bus_addr), .bus_wdata_i(bus_wdata), .bus_wr_i(bus_wr),
    .bus_rd_i(bus_rd), .bus_rdata_o(rdata), .freq_cmd_i(freq_cmd),
    .freq_sel_o(freq_sel), .preset_sel_o(preset_sel), .speed_idx_o(speed_idx),
    .ramp_idx_o(ramp_idx), .acc_time_o(acc_time), .dec_time_o(dec_time),
    .func_act_o(func_act), .ext_alarm_o(ext_alarm), .setting_error_o(set_err)
  );

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Hang guard, far above the roughly 725 cycles the run needs
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic chk(input logic [35:0] exp, input logic [35:0] act);
    check_count++;
    if (act !== exp) begin
      fails++;
      $display("FAIL t=%0t exp=%h got=%h", $time, exp, act);
    end
  endtask

  // Edge passes after the strobe so back-to-back calls never double-drive it
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge sys_clk_i);
    bus_wr    <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  task automatic rd(input logic [5:0] a);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge sys_clk_i);
    bus_rd   <= 1'b0;
    #1;
    rd_val = rdata;
    @(posedge sys_clk_i);
  endtask

  // Outputs are steady long before the check, so edge ordering cannot matter
  task automatic settle;
    repeat (6) @(posedge sys_clk_i);
  endtask

  function automatic logic [35:0] preset_val(input int n);
    return (n == 15) ? 36'h0_0000_2EE0 : 36'(n * 700);
  endfunction

  function automatic logic code_ok(input int c);
    return c <= 22 || c == 24 || c == 25 || c == 26 || c == 30 || c == 31 || c == 35;
  endfunction

  // Main sequence
  initial begin
    repeat (6) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge sys_clk_i);
    for (int k = 0; k < 9; k++) begin
      rd(`DIFM_ADDR_TERM + 6'(k));
      chk(36'(k), 36'(rd_val));
    end
    chk(36'h0_0000_0258, 36'(acc_time));
    // Presets, the top limit accepted and one above it dropped
    for (int n = 1; n < 16; n++)
      wr(`DIFM_ADDR_PRESET + 6'(n), 32'(n * 700));
    wr(`DIFM_ADDR_PRESET + 6'h0F, 32'h0000_2EE0);
    wr(`DIFM_ADDR_PRESET + 6'h01, 32'h0000_2EE1);
    for (int n = 0; n < 16; n++) begin
      press <= 9'(n);
      settle();
      chk(36'(n), 36'(speed_idx));
      chk((n != 0) ? preset_val(n) : 36'(freq_cmd), 36'(freq_sel));
      chk(36'(n != 0), 36'(preset_sel));
    end
    // Ramp pairs, zero and over-range writes dropped
    for (int k = 0; k < 4; k++) begin
      wr(`DIFM_ADDR_RAMP + 6'(2 * k), 32'(1000 + k));
      wr(`DIFM_ADDR_RAMP + 6'(2 * k + 1), 32'(2000 + k));
    end
    wr(`DIFM_ADDR_RAMP, 32'h0000_0000);
    wr(`DIFM_ADDR_RAMP + 6'h01, 32'h0005_7E41);
    wr(`DIFM_ADDR_RAMP + 6'h02, 32'h0005_7E40);
    for (int k = 0; k < 4; k++) begin
      press <= 9'(k << 4);
      settle();
      chk(36'(k), 36'(ramp_idx));
      chk((k == 1) ? 36'h0_0005_7E40 : 36'(1000 + k), 36'(acc_time));
      chk(36'(2000 + k), 36'(dec_time));
    end
    // Codes 0 to 35 on the last terminal, closed then open
    for (int c = 0; c < 36; c++) begin
      press <= 9'h000;
      wr(`DIFM_ADDR_TERM + 6'h08, 32'(c));
      press <= 9'h100;
      settle();
      chk(code_ok(c) ? (36'h1 << c) : 36'h0, func_act);
      press <= 9'h000;
      settle();
      chk(36'h0, func_act);
      chk(36'(c == 9), 36'(ext_alarm));
    end
    // Second source switch refused while the alternate one is assigned
    wr(`DIFM_ADDR_TERM + 6'h07, 32'h0000_000B);
    settle();
    chk(36'h1, 36'(set_err));
    rd(`DIFM_ADDR_TERM + 6'h07);
    chk(36'h7, 36'(rd_val));
    rd(`DIFM_ADDR_STATUS);
    chk(36'h40, 36'(rd_val));
    wr(`DIFM_ADDR_STATUS, 32'h0000_0040);
    settle();
    chk(36'h0, 36'(set_err));
    give_verdict();
  end
endmodule // tb_top
